/* core/tx_skid_buffer.sv */
`timescale 1ns/1ps
`default_nettype none

module tx_skid_buffer #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         flush,
  // Fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);

  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("tx_skid_buffer: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             count;
  } bufState_t;

  bufState_t b_q;
  bufState_t b_d;
  logic      doPush;
  logic      doPop;

  assign inReady  = (b_q.count != (PW+1)'(DEPTH));
  assign outValid = (b_q.count != '0);
  assign outData  = b_q.mem[b_q.rp];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  always_comb begin
    b_d = b_q;
    if (doPush) begin
      b_d.mem[b_q.wp] = inData;
      b_d.wp          = b_q.wp + 1'b1;
    end
    if (doPop) begin
      b_d.rp = b_q.rp + 1'b1;
    end
    b_d.count = b_q.count + (PW+1)'(doPush) - (PW+1)'(doPop);
    // Disabling the port discards anything still queued
    if (flush) begin
      b_d.wp    = '0;
      b_d.rp    = '0;
      b_d.count = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

endmodule : tx_skid_buffer

`default_nettype wire

/* core/usart_defs.svh */
`ifndef USART_DEFS_SVH
`define USART_DEFS_SVH

// ****************************************************************
// Register port geometry
// ****************************************************************
`define USART_ADDR_W      4
`define USART_DATA_W      16

// ****************************************************************
// Register offsets
// ****************************************************************
`define USART_OFS_CTRL    4'h0
`define USART_OFS_DIV     4'h1
`define USART_OFS_TXBUF   4'h2
`define USART_OFS_STATUS  4'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define USART_CTRL_W      10
`define USART_ST_FLAG     0
`define USART_ST_BUSY     1
`define USART_ST_FULL     2
`define USART_ST_DLINE    3
`define USART_ST_DROP     4
`define USART_ST_CLINE    5
`define USART_CHAR_W      8

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define USART_CTRL_RST    10'h000
`define USART_DIV_RST     16'h0003
`define USART_BITS_8      4'h8
`define USART_BITS_9      4'h9

`endif

/* core/usart_pkg.sv */
`include "usart_defs.svh"

package usart_pkg;

  // Control bits, declared from the top bit down
  typedef struct packed {
    logic transmitInterruptEnable;
    logic clockIdlePolarity;
    logic ninthTransmitBit;
    logic nineBitTransmit;
    logic transmitEnable;
    logic continuousReceiveEnable;
    logic singleReceiveEnable;
    logic serialPortEnable;
    logic masterClockSource;
    logic clockedMode;
  } ctrl_t;

  // One character as it waits in the buffer
  typedef struct packed {
    logic                       nine;
    logic                       ninth;
    logic [`USART_CHAR_W-1:0]   data;
  } txWord_t;

  typedef enum logic [1:0] {SH_IDLE, SH_LEAD, SH_TRAIL} shift_t;

  typedef struct packed {
    ctrl_t                      ctrl;
    logic [`USART_DATA_W-1:0]   divisor;
    logic [`USART_DATA_W-1:0]   divCnt;
    shift_t                     fsm;
    logic [`USART_CHAR_W:0]     shifter;
    logic [3:0]                 bitsLeft;
    logic                       clkOut;
    logic                       dataOut;
    logic                       clkOe_n;
    logic                       dataOe_n;
    logic [`USART_DATA_W-1:0]   rdata;
    logic                       txFlag;
    logic                       irqReq;
    logic                       dropped;
    logic                       dinMeta;
    logic                       dinSync;
    logic                       cinMeta;
    logic                       cinSync;
  } state_t;

endpackage : usart_pkg

/* core/usart_sync_master_tx.sv */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "usart_defs.svh"

// Contract
// - Two lines only, never send while receiving
// - No start or stop bits
// - Transmit needs mode bits set, receives clear
// - Clock pin driver on whenever synchronous configured
// - Data changes on the leading clock edge
// - Exactly one clock per data bit
// - Polarity set: idle high, change on fall
// - Polarity clear: idle low, change on rise
// - Transmit drives both data and clock pins
// - New character waits until shifter drained
// - Empty shifter loads at once, first leading edge a full half-bit later
// - Bit holds from leading edge to next
// - Shift register not visible to software
// - Data pin direction handled by the unit
module usart_sync_master_tx #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  // Register port
  input  wire logic [`USART_ADDR_W-1:0]  regAddr,
  input  wire logic [`USART_DATA_W-1:0]  regWdata,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic      [`USART_DATA_W-1:0]  regRdata,
  // Clock pin
  input  wire logic                      clkPinIn,
  output logic                           clkPinOut,
  output logic                           clkPinOe_n,
  // Data pin
  input  wire logic                      dataPinIn,
  output logic                           dataPinOut,
  output logic                           dataPinOe_n,
  // Events
  output logic                           transmitFlag,
  output logic                           transmitIntReq
);
  import usart_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  state_t  s_q;
  state_t  s_d;
  txWord_t pushWord;
  txWord_t bufOut;
  logic    bufInReady;
  logic    bufOutValid;
  logic    bufPush;
  logic    bufPop;
  logic    syncCfg;
  logic    rxSel;
  logic    masterTx;
  logic    active;
  logic    halfTick;
  logic    leadEdge;
  logic    trailEdge;
  logic    lastTrail;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  assign syncCfg   = s_q.ctrl.clockedMode & s_q.ctrl.masterClockSource
                   & s_q.ctrl.serialPortEnable;
  assign rxSel     = s_q.ctrl.singleReceiveEnable | s_q.ctrl.continuousReceiveEnable;
  assign masterTx  = syncCfg & ~rxSel;
  assign active    = masterTx & s_q.ctrl.transmitEnable;
  assign halfTick  = (s_q.divCnt == s_q.divisor);
  assign leadEdge  = (s_q.fsm == SH_LEAD) & active & halfTick;
  assign trailEdge = (s_q.fsm == SH_TRAIL) & active & halfTick;
  assign lastTrail = trailEdge & (s_q.bitsLeft == 4'h1);

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************
  // Nine-bit option and ninth bit are taken with the character, so a
  // later change of those controls cannot corrupt a queued word.
  assign pushWord.nine  = s_q.ctrl.nineBitTransmit;
  assign pushWord.ninth = s_q.ctrl.ninthTransmitBit;
  assign pushWord.data  = regWdata[`USART_CHAR_W-1:0];
  assign bufPush        = regWrite & (regAddr == `USART_OFS_TXBUF);
  assign bufPop         = (s_q.fsm == SH_IDLE) & active;

  tx_skid_buffer #(
    .W     ($bits(txWord_t)),
    .DEPTH (BUF_DEPTH)
  ) u_txbuf (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .flush    (~s_q.ctrl.serialPortEnable),
    .inValid  (bufPush),
    .inReady  (bufInReady),
    .inData   (pushWord),
    .outValid (bufOutValid),
    .outReady (bufPop),
    .outData  (bufOut)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;

    // Pin level synchronisers, first stage read only by the second
    s_d.dinMeta = dataPinIn;
    s_d.dinSync = s_q.dinMeta;
    s_d.cinMeta = clkPinIn;
    s_d.cinSync = s_q.cinMeta;

    // Register writes
    if (regWrite) begin
      unique case (regAddr)
        `USART_OFS_CTRL:   s_d.ctrl = ctrl_t'(regWdata[`USART_CTRL_W-1:0]);
        `USART_OFS_DIV:    s_d.divisor = regWdata;
        `USART_OFS_STATUS: if (regWdata[`USART_ST_DROP]) s_d.dropped = 1'b0;
        default: ;
      endcase
    end
    // A drop in the same cycle as its clear still lands
    if (bufPush && !bufInReady) begin
      s_d.dropped = 1'b1;
    end

    // Read data stand for one cycle only; the shifter has no address
    s_d.rdata = '0;
    if (regRead) begin
      unique case (regAddr)
        `USART_OFS_CTRL:   s_d.rdata = `USART_DATA_W'(s_q.ctrl);
        `USART_OFS_DIV:    s_d.rdata = s_q.divisor;
        `USART_OFS_STATUS: begin
          s_d.rdata[`USART_ST_FLAG]  = s_q.txFlag;
          s_d.rdata[`USART_ST_BUSY]  = (s_q.fsm != SH_IDLE);
          s_d.rdata[`USART_ST_FULL]  = ~bufInReady;
          s_d.rdata[`USART_ST_DLINE] = s_q.dinSync;
          s_d.rdata[`USART_ST_DROP]  = s_q.dropped;
          s_d.rdata[`USART_ST_CLINE] = s_q.cinSync;
        end
        default:           s_d.rdata = '0;
      endcase
    end

    // Half-bit divider, held at zero between characters so the first
    // half-bit after a load is always full length
    if (s_q.fsm == SH_IDLE || halfTick) begin
      s_d.divCnt = '0;
    end else begin
      s_d.divCnt = s_q.divCnt + 1'b1;
    end

    // Shifter
    unique case (s_q.fsm)
      SH_IDLE: begin
        s_d.clkOut = s_q.ctrl.clockIdlePolarity;
        if (bufPop && bufOutValid) begin
          // Only data bits go into the shifter, no framing
          s_d.shifter  = {bufOut.ninth, bufOut.data};
          s_d.bitsLeft = bufOut.nine ? `USART_BITS_9 : `USART_BITS_8;
          s_d.fsm      = SH_LEAD;
        end
      end
      SH_LEAD: begin
        if (!active) begin
          s_d.fsm    = SH_IDLE;
          s_d.clkOut = s_q.ctrl.clockIdlePolarity;
        end else if (halfTick) begin
          s_d.dataOut = s_q.shifter[0];
          s_d.shifter = s_q.shifter >> 1;
          s_d.clkOut  = ~s_q.ctrl.clockIdlePolarity;
          s_d.fsm     = SH_TRAIL;
        end
      end
      SH_TRAIL: begin
        if (!active) begin
          s_d.fsm    = SH_IDLE;
          s_d.clkOut = s_q.ctrl.clockIdlePolarity;
        end else if (halfTick) begin
          // Data keep their level here until the next leading edge
          s_d.clkOut   = s_q.ctrl.clockIdlePolarity;
          s_d.bitsLeft = s_q.bitsLeft - 4'h1;
          s_d.fsm      = (s_q.bitsLeft == 4'h1) ? SH_IDLE : SH_LEAD;
        end
      end
    endcase

    // Pin drivers follow configuration; receive selection frees data
    s_d.clkOe_n  = ~syncCfg;
    s_d.dataOe_n = ~masterTx;

    // Transmit flag is a level: room in the buffer while enabled
    s_d.txFlag = s_q.ctrl.transmitEnable & bufInReady;
    s_d.irqReq = s_q.txFlag & s_q.ctrl.transmitInterruptEnable;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.ctrl     <= ctrl_t'(`USART_CTRL_RST);
      s_q.divisor  <= `USART_DIV_RST;
      s_q.fsm      <= SH_IDLE;
      s_q.clkOe_n  <= 1'b1;
      s_q.dataOe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign regRdata       = s_q.rdata;
  assign clkPinOut      = s_q.clkOut;
  assign clkPinOe_n     = s_q.clkOe_n;
  assign dataPinOut     = s_q.dataOut;
  assign dataPinOe_n    = s_q.dataOe_n;
  assign transmitFlag   = s_q.txFlag;
  assign transmitIntReq = s_q.irqReq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [3:0]               chkEdges;
  logic [3:0]               chkBits;
  logic [`USART_CHAR_W:0]   chkWord;

  // Counts leading edges of the character in flight
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chkEdges <= '0;
      chkBits  <= '0;
      chkWord  <= '0;
    end else if (s_q.fsm == SH_IDLE && bufPop && bufOutValid) begin
      chkEdges <= '0;
      chkBits  <= bufOut.nine ? `USART_BITS_9 : `USART_BITS_8;
      chkWord  <= {bufOut.ninth, bufOut.data};
    end else if (leadEdge) begin
      chkEdges <= chkEdges + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence seqLastWithNext;
    lastTrail && bufOutValid;
  endsequence

  sequence seqReload;
    (s_q.fsm == SH_IDLE) ##1 (s_q.fsm == SH_LEAD);
  endsequence

  chk_idle_low: assert property (
    (s_q.fsm != SH_TRAIL && !s_q.ctrl.clockIdlePolarity && $stable(s_q.ctrl))
      |-> !clkPinOut)
    else $error("clock not low outside a bit with polarity clear");

  chk_idle_high: assert property (
    (s_q.fsm != SH_TRAIL && s_q.ctrl.clockIdlePolarity && $stable(s_q.ctrl))
      |-> clkPinOut)
    else $error("clock not high outside a bit with polarity set");

  chk_data_on_lead: assert property (
    $changed(dataPinOut) |-> (s_q.fsm == SH_TRAIL)
                          && (clkPinOut != s_q.ctrl.clockIdlePolarity))
    else $error("data changed away from a leading edge");

  // Any cycle of a character that is not a leading edge keeps the bit,
  // so this also holds with the shortest half-bit of one cycle
  chk_bit_hold: assert property (
    (s_q.fsm != SH_IDLE && !leadEdge) |=> $stable(dataPinOut))
    else $error("data moved before the next leading edge");

  chk_clock_count: assert property (
    lastTrail |-> (chkEdges == chkBits))
    else $error("clock count differs from data bit count");

  chk_first_bit: assert property (
    (leadEdge && chkEdges == 4'h0) |=> (dataPinOut == chkWord[0]))
    else $error("first clocked bit is not the lowest data bit");

  chk_last_bit: assert property (
    (leadEdge && chkEdges == chkBits - 4'h1)
      |=> (dataPinOut == chkWord[chkBits - 4'h1]))
    else $error("last clocked bit is not the top data bit");

  chk_load_now: assert property (
    (s_q.fsm == SH_IDLE && active && bufOutValid) |=> (s_q.fsm == SH_LEAD))
    else $error("waiting character not loaded at once");

  chk_back_to_back: assert property (
    seqLastWithNext |=> seqReload)
    else $error("queued character not started after the last bit");

  chk_wait_queue: assert property (
    (s_q.fsm != SH_IDLE && s_q.ctrl.serialPortEnable && bufOutValid && !bufPush)
      |=> bufOutValid)
    else $error("queued character left while shifter busy");

  chk_clk_driver: assert property (
    syncCfg |=> !clkPinOe_n)
    else $error("clock pin not driven in synchronous master mode");

  chk_data_driver: assert property (
    masterTx |=> !dataPinOe_n)
    else $error("data pin not driven in master transmit");

  chk_half_duplex: assert property (
    rxSel |=> (dataPinOe_n && s_q.fsm == SH_IDLE))
    else $error("data driven while receive selected");

  chk_tx_flag: assert property (
    (s_q.ctrl.transmitEnable && bufInReady) |=> transmitFlag)
    else $error("flag missing while buffer has room");

  chk_flag_clear: assert property (
    !bufInReady |=> !transmitFlag)
    else $error("flag raised while buffer is full");

  chk_no_tsr_read: assert property (
    (regRead && regAddr == `USART_OFS_TXBUF) |=> (regRdata == '0))
    else $error("shift data visible through the register port");

endmodule : usart_sync_master_tx

`default_nettype wire

/* dv/sync_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sync_slave_model (
  // Clock and capture clear
  input  wire logic        ref_clk,
  input  wire logic        clear,
  input  wire logic        idleHigh,
  // Master pins
  input  wire logic        clkPinOut,
  input  wire logic        clkPinOe_n,
  input  wire logic        dataPinOut,
  input  wire logic        dataPinOe_n,
  // Lines and captured bits
  output logic             clkLine,
  output logic             dataLine,
  output logic [31:0]      rxBits,
  output logic [7:0]       rxCount,
  output logic [7:0]       holdErrs
);
  logic clkLast  = 1'b0;
  logic dataLast = 1'b0;
  logic clkOn    = 1'b0;
  logic dataOn   = 1'b0;
  logic moved;
  logic leadEdge;
  logic trailEdge;

  // Released lines keep moving, so a stale level never passes for data
  assign clkLine   = clkPinOe_n ? ~clkLast : clkPinOut;
  assign dataLine  = dataPinOe_n ? ~dataLast : dataPinOut;
  assign moved     = clkOn && !clkPinOe_n && (clkLine != clkLast);
  assign leadEdge  = moved && (clkLine != idleHigh);
  assign trailEdge = moved && (clkLine == idleHigh);

  initial holdErrs = 8'h00;

  always @(posedge ref_clk) begin
    clkLast  <= clkLine;
    dataLast <= dataLine;
    clkOn    <= !clkPinOe_n;
    dataOn   <= !dataPinOe_n;
    if (clear) begin
      rxBits  <= '0;
      rxCount <= '0;
    end else if (trailEdge) begin
      rxBits[rxCount[4:0]] <= dataLine;
      rxCount              <= rxCount + 8'h01;
    end
    // Data may move only together with a leading clock edge
    if (dataOn && !dataPinOe_n && clkOn && (dataLine != dataLast) && !leadEdge) begin
      holdErrs <= holdErrs + 8'h01;
    end
  end
endmodule : sync_slave_model

`default_nettype wire

/* dv/usart_sync_master_tx_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usart_defs.svh"

module usart_sync_master_tx_test;
  import usart_pkg::*;

  logic        ref_clk;
  logic        sys_rst;
  logic [3:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [15:0] regRdata;
  logic        clkPinOut;
  logic        clkPinOe_n;
  logic        dataPinOut;
  logic        dataPinOe_n;
  logic        transmitFlag;
  logic        transmitIntReq;
  logic        clkLine;
  logic        dataLine;
  logic        clear;
  logic [31:0] rxBits;
  logic [7:0]  rxCount;
  logic [7:0]  holdErrs;
  ctrl_t       cfg;
  ctrl_t       c;
  logic [15:0] r;
  logic [31:0] rnd;
  logic [31:0] seed;
  int          div;
  int          err_total;
  int          compares;

  usart_sync_master_tx #(.BUF_DEPTH(2)) usart_sync_master_tx_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .clkPinIn(clkLine), .clkPinOut(clkPinOut), .clkPinOe_n(clkPinOe_n),
    .dataPinIn(dataLine), .dataPinOut(dataPinOut), .dataPinOe_n(dataPinOe_n),
    .transmitFlag(transmitFlag), .transmitIntReq(transmitIntReq));

  sync_slave_model sync_slave_model_i (
    .ref_clk(ref_clk), .clear(clear), .idleHigh(cfg.clockIdlePolarity),
    .clkPinOut(clkPinOut), .clkPinOe_n(clkPinOe_n), .dataPinOut(dataPinOut),
    .dataPinOe_n(dataPinOe_n), .clkLine(clkLine), .dataLine(dataLine),
    .rxBits(rxBits), .rxCount(rxCount), .holdErrs(holdErrs));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Bench tasks
  // ****************************************************************
  task automatic print_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
    @(posedge ref_clk);
  endtask : rd

  task automatic setCfg(input ctrl_t v);
    cfg <= v;
    wr(`USART_OFS_CTRL, {6'h00, v});
  endtask : setCfg

  // Let a polarity change settle before the slave starts counting
  task automatic flushModel();
    cycles(3);
    clear <= 1'b1;
    @(posedge ref_clk);
    clear <= 1'b0;
  endtask : flushModel

  task automatic waitBits(input int n, input int limit);
    int k;
    k = 0;
    while (rxCount < n && k < limit) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= limit) begin
      err_total++;
      print_verdict();
    end
  endtask : waitBits

  function automatic logic [31:0] expBits(input logic [7:0] d, input logic nine,
                                          input logic ninth);
    expBits = nine ? {23'h0, ninth, d} : {24'h0, d};
  endfunction : expBits

  task automatic send(input logic [7:0] d, input logic nine, input logic ninth);
    ctrl_t v;
    int    n;
    v = cfg;
    v.nineBitTransmit  = nine;
    v.ninthTransmitBit = ninth;
    setCfg(v);
    flushModel();
    n = nine ? 9 : 8;
    wr(`USART_OFS_TXBUF, {8'h00, d});
    waitBits(n, 2 * n * (div + 1) + 4);
    cycles(2 * (div + 1) + 4);
    check(rxCount, n);
    check(rxBits, expBits(d, nine, ninth));
    check(clkLine, v.clockIdlePolarity);
  endtask : send

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed      = 32'h32e6_6957;
    err_total = 0;
    compares  = 0;
    div       = 3;
    cfg       = '0;
    sys_rst   = 1'b1;
    clear     = 1'b1;
    regAddr   = 4'h0;
    regWdata  = 16'h0000;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    clear   <= 1'b0;
    @(posedge ref_clk);
    check(clkPinOe_n, 1'b1);
    check(dataPinOe_n, 1'b1);
    check(transmitFlag, 1'b0);
    rd(`USART_OFS_STATUS, r);
    check(r & 16'h0017, 16'h0000);
    rd(`USART_OFS_TXBUF, r);
    check(r, 16'h0000);
    wr(4'h9, 16'hffff);
    rd(4'h9, r);
    check(r, 16'h0000);
    wr(`USART_OFS_DIV, 16'h0003);
    c = '0;
    c.clockedMode       = 1'b1;
    c.masterClockSource = 1'b1;
    c.serialPortEnable  = 1'b1;
    setCfg(c);
    c.transmitEnable          = 1'b1;
    c.transmitInterruptEnable = 1'b1;
    setCfg(c);
    cycles(3);
    check(clkPinOe_n, 1'b0);
    check(dataPinOe_n, 1'b0);
    check(transmitFlag, 1'b1);
    check(transmitIntReq, 1'b1);
    check(clkLine, 1'b0);
    send(8'hff, 1'b1, 1'b0);
    c.clockIdlePolarity = 1'b1;
    setCfg(c);
    send(8'h00, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      div = int'(rnd[5:4]);
      wr(`USART_OFS_DIV, {14'h0000, rnd[5:4]});
      c = cfg;
      c.clockIdlePolarity = rnd[0];
      setCfg(c);
      send(rnd[15:8], rnd[1], rnd[2]);
    end
    // Back to back: one in the shifter, two waiting, the fourth refused
    c = cfg;
    c.nineBitTransmit = 1'b0;
    setCfg(c);
    div = 3;
    wr(`USART_OFS_DIV, 16'h0003);
    flushModel();
    wr(`USART_OFS_TXBUF, 16'h003c);
    wr(`USART_OFS_TXBUF, 16'h00c3);
    wr(`USART_OFS_TXBUF, 16'h005a);
    cycles(1);
    check(transmitFlag, 1'b0);
    wr(`USART_OFS_TXBUF, 16'h0099);
    rd(`USART_OFS_STATUS, r);
    check(r & 16'h0016, 16'h0016);
    waitBits(24, 3 * 16 * 4 + 20);
    cycles(40);
    check(rxCount, 24);
    check(rxBits, 32'h005a_c33c);
    check(transmitFlag, 1'b1);
    wr(`USART_OFS_STATUS, 16'h0010);
    rd(`USART_OFS_STATUS, r);
    check(r & 16'h0010, 16'h0000);
    check(r[`USART_ST_DLINE], 1'b0);
    check(r[`USART_ST_CLINE], cfg.clockIdlePolarity);
    // Either receive enable turns the unit away from transmitting
    for (int i = 0; i < 2; i++) begin
      c = cfg;
      c.singleReceiveEnable     = (i == 0);
      c.continuousReceiveEnable = (i == 1);
      setCfg(c);
      flushModel();
      check(dataPinOe_n, 1'b1);
      check(clkPinOe_n, 1'b0);
      wr(`USART_OFS_TXBUF, 16'h0081);
      cycles(80);
      check(rxCount, 0);
      c.serialPortEnable = 1'b0;
      setCfg(c);
      c.serialPortEnable        = 1'b1;
      c.singleReceiveEnable     = 1'b0;
      c.continuousReceiveEnable = 1'b0;
      setCfg(c);
    end
    check(holdErrs, 0);
    print_verdict();
  end
endmodule : usart_sync_master_tx_test

`default_nettype wire
